/* File: src/srt_pkg.sv */
// Contract
// - Mode 1,1: sample rising, change falling
// - Ignore clock and data while deselected
// - Select starts frame, deselect clears state
// - Mid-frame deselect aborts without register change
// - Clock may pause while selected
// - Echo address bits on target output; the target echoes bits 14 to 1, each on the next falling edge, and never bit 0
// - One bit each way every clock
// - Unused location reads zero
// - Writes to unused locations ignored
// - Writable registers read back; revision read-only
// - Write: one, 15-bit address, data
// - Further write bytes go to next address
// - Read: zero, address, data next falling
// - Single read ends after eighth bit
// - Continued read clocks shift following registers
// - Controller stops clock, then deselects
package srt_pkg;
    localparam int ADDR_W = 15;
    localparam int DATA_W = 8;
    localparam logic DIR_WRITE = 1'b1;
    localparam logic DIR_READ = 1'b0;
    // Read-only revision location
    localparam logic [ADDR_W-1:0] REV_ADDR = 15'h7fff;
    localparam logic [DATA_W-1:0] DATA_RST = 8'h00;
    localparam logic [ADDR_W-1:0] ADDR_RST = 15'h0000;
    localparam logic [3:0] ADDR_LAST = 4'he;
    localparam logic [3:0] DATA_LAST = 4'h7;
    localparam logic [3:0] HDR_LAST = 4'hf;
    // Host clock and fastest serial clock
    localparam int CLK_PERIOD_NS = 20;
    localparam int SPI_FMAX_KHZ = 3000;
    // Least half period, rounded up to whole cycles
    localparam int HALF_CYC = (1000000 + 2 * SPI_FMAX_KHZ * CLK_PERIOD_NS - 1) / (2 * SPI_FMAX_KHZ * CLK_PERIOD_NS);

    typedef enum logic [1:0] {
        DS_CMD = 2'b00,
        DS_ADDR = 2'b01,
        DS_DATA = 2'b10
    } srt_dev_state_e;

    typedef enum logic [2:0] {
        HS_IDLE = 3'b000,
        HS_SEL = 3'b001,
        HS_LOW = 3'b010,
        HS_HIGH = 3'b011,
        HS_END = 3'b100
    } srt_host_state_e;
endpackage : srt_pkg

/* File: src/srt_link_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface srt_link_if;
    logic cs_n;
    logic sclk;
    logic mosi;
    logic miso;

    modport device (
        input cs_n,
        input sclk,
        input mosi,
        output miso
    );

    modport host (
        output cs_n,
        output sclk,
        output mosi,
        input miso
    );
endinterface : srt_link_if
`default_nettype wire

/* File: src/srt_target.sv */
`timescale 1ns/1ps
`default_nettype none
module srt_target #(
    parameter int NUM_REGS = 16,
    // Arbitrary value
    parameter logic [7:0] REVISION = 8'h5a
) (
    input wire logic clock,
    input wire logic nrst,
    srt_link_if.device link,
    output logic wr_valid,
    output logic [srt_pkg::ADDR_W-1:0] wr_addr,
    output logic [srt_pkg::DATA_W-1:0] wr_data
);
    localparam int IDX_W = $clog2(NUM_REGS);

    srt_pkg::srt_dev_state_e state_ff, nxt_state;
    logic [3:0] cnt_ff, nxt_cnt;
    logic dir_ff, nxt_dir;
    logic [srt_pkg::ADDR_W-1:0] addr_ff, nxt_addr;
    logic [6:0] rx_ff, nxt_rx;
    logic [srt_pkg::DATA_W-1:0] tx_ff, nxt_tx;
    logic echo_ff, nxt_echo;
    logic miso_ff, nxt_miso;
    logic we;
    logic we_ok;
    logic frame_clr;
    logic [srt_pkg::ADDR_W-1:0] full_addr;
    logic [srt_pkg::ADDR_W-1:0] addr_inc;
    logic [srt_pkg::DATA_W-1:0] full_data;
    logic [srt_pkg::DATA_W-1:0] mem_ff [NUM_REGS];
    logic [srt_pkg::ADDR_W-1:0] hold_addr_ff, nxt_hold_addr;
    logic [srt_pkg::DATA_W-1:0] hold_data_ff, nxt_hold_data;
    logic tgl_ff, nxt_tgl;
    logic [2:0] sync_ff;
    logic seen_ff, nxt_seen;
    logic wr_valid_ff, nxt_wr_valid;
    logic [srt_pkg::ADDR_W-1:0] wr_addr_ff, nxt_wr_addr;
    logic [srt_pkg::DATA_W-1:0] wr_data_ff, nxt_wr_data;

    // Register lookup: writable block, revision, zero elsewhere
    function automatic logic [srt_pkg::DATA_W-1:0] rd_byte(input logic [srt_pkg::ADDR_W-1:0] a);
        logic [srt_pkg::DATA_W-1:0] v;
        v = srt_pkg::DATA_RST;
        if (a < srt_pkg::ADDR_W'(NUM_REGS)) begin
            v = mem_ff[a[IDX_W-1:0]];
        end else if (a == srt_pkg::REV_ADDR) begin
            v = REVISION;
        end
        return v;
    endfunction : rd_byte

    // Deselect holds the frame logic cleared, so clock and data are ignored
    assign frame_clr = link.cs_n | ~nrst;
    assign full_addr = {addr_ff[srt_pkg::ADDR_W-2:0], link.mosi};
    assign full_data = {rx_ff, link.mosi};
    assign addr_inc = addr_ff + 15'h0001;
    assign we_ok = we & (addr_ff < srt_pkg::ADDR_W'(NUM_REGS));

    // Frame sequencer; advances only on clock edges, so pauses are harmless
    always_comb begin
        nxt_state = state_ff;
        nxt_cnt = cnt_ff;
        nxt_dir = dir_ff;
        nxt_addr = addr_ff;
        nxt_rx = full_data[6:0];
        nxt_tx = tx_ff;
        nxt_echo = link.mosi;
        we = 1'b0;
        unique case (state_ff)
            srt_pkg::DS_CMD: begin
                nxt_dir = link.mosi;
                nxt_state = srt_pkg::DS_ADDR;
                nxt_cnt = 4'h0;
            end
            srt_pkg::DS_ADDR: begin
                nxt_addr = full_addr;
                nxt_cnt = cnt_ff + 4'h1;
                if (cnt_ff == srt_pkg::ADDR_LAST) begin
                    nxt_state = srt_pkg::DS_DATA;
                    nxt_cnt = 4'h0;
                    nxt_tx = rd_byte(full_addr);
                end
            end
            srt_pkg::DS_DATA: begin
                nxt_cnt = cnt_ff + 4'h1;
                if (cnt_ff == srt_pkg::DATA_LAST) begin
                    nxt_cnt = 4'h0;
                    nxt_addr = addr_inc;
                    if (dir_ff == srt_pkg::DIR_WRITE) begin
                        we = 1'b1;
                    end else begin
                        nxt_tx = rd_byte(addr_inc);
                    end
                end
            end
            default: begin
                nxt_state = srt_pkg::DS_CMD;
            end
        endcase
    end

    // Sampling on the rising serial clock edge
    always_ff @(posedge link.sclk or posedge frame_clr) begin
        if (frame_clr) begin
            state_ff <= srt_pkg::DS_CMD;
            cnt_ff <= 4'h0;
            dir_ff <= srt_pkg::DIR_READ;
            addr_ff <= srt_pkg::ADDR_RST;
            rx_ff <= 7'h00;
            tx_ff <= srt_pkg::DATA_RST;
            echo_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            cnt_ff <= nxt_cnt;
            dir_ff <= nxt_dir;
            addr_ff <= nxt_addr;
            rx_ff <= nxt_rx;
            tx_ff <= nxt_tx;
            echo_ff <= nxt_echo;
        end
    end

    // Output bit: echo in address phase, read data, else zero
    always_comb begin
        nxt_miso = 1'b0;
        if (state_ff == srt_pkg::DS_ADDR && cnt_ff != 4'h0) begin
            nxt_miso = echo_ff;
        end else if (state_ff == srt_pkg::DS_DATA && dir_ff == srt_pkg::DIR_READ) begin
            nxt_miso = tx_ff[~cnt_ff[2:0]];
        end
    end

    // Output changes on the falling serial clock edge
    always_ff @(negedge link.sclk or posedge frame_clr) begin
        if (frame_clr) begin
            miso_ff <= 1'b0;
        end else begin
            miso_ff <= nxt_miso;
        end
    end

    assign link.miso = miso_ff;

    // Held write word moves only when a whole byte lands in a writable register
    always_comb begin
        nxt_hold_addr = hold_addr_ff;
        nxt_hold_data = hold_data_ff;
        nxt_tgl = tgl_ff;
        if (we_ok) begin
            nxt_hold_addr = addr_ff;
            nxt_hold_data = full_data;
            nxt_tgl = ~tgl_ff;
        end
    end

    // Registers live on the link clock so a read needs no crossing in half a bit
    always_ff @(posedge link.sclk or negedge nrst) begin
        if (!nrst) begin
            for (int i = 0; i < NUM_REGS; i++) begin
                mem_ff[i] <= srt_pkg::DATA_RST;
            end
            hold_addr_ff <= srt_pkg::ADDR_RST;
            hold_data_ff <= srt_pkg::DATA_RST;
            tgl_ff <= 1'b0;
        end else begin
            hold_addr_ff <= nxt_hold_addr;
            hold_data_ff <= nxt_hold_data;
            tgl_ff <= nxt_tgl;
            if (we_ok) begin
                mem_ff[addr_ff[IDX_W-1:0]] <= full_data;
            end
        end
    end

    // Write notice toward the system clock; held word is stable for a whole byte
    always_comb begin
        nxt_seen = seen_ff;
        nxt_wr_valid = 1'b0;
        nxt_wr_addr = wr_addr_ff;
        nxt_wr_data = wr_data_ff;
        if (sync_ff[1] == sync_ff[2] && sync_ff[2] != seen_ff) begin
            nxt_seen = sync_ff[2];
            nxt_wr_valid = 1'b1;
            nxt_wr_addr = hold_addr_ff;
            nxt_wr_data = hold_data_ff;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            sync_ff <= 3'h0;
            seen_ff <= 1'b0;
            wr_valid_ff <= 1'b0;
            wr_addr_ff <= srt_pkg::ADDR_RST;
            wr_data_ff <= srt_pkg::DATA_RST;
        end else begin
            sync_ff <= {sync_ff[1:0], tgl_ff};
            seen_ff <= nxt_seen;
            wr_valid_ff <= nxt_wr_valid;
            wr_addr_ff <= nxt_wr_addr;
            wr_data_ff <= nxt_wr_data;
        end
    end

    assign wr_valid = wr_valid_ff;
    assign wr_addr = wr_addr_ff;
    assign wr_data = wr_data_ff;
endmodule : srt_target
`default_nettype wire

/* File: src/srt_controller.sv */
`timescale 1ns/1ps
`default_nettype none
module srt_controller #(
    parameter int HALF = srt_pkg::HALF_CYC
) (
    input wire logic clock,
    input wire logic nrst,
    srt_link_if.host link,
    input wire logic cmd_valid,
    input wire logic cmd_write,
    input wire logic [srt_pkg::ADDR_W-1:0] cmd_addr,
    input wire logic [7:0] cmd_extra,
    input wire logic [srt_pkg::DATA_W-1:0] cmd_wdata,
    output logic busy,
    output logic wdata_take,
    output logic rd_valid,
    output logic [srt_pkg::DATA_W-1:0] rd_data,
    output logic done
);
    srt_pkg::srt_host_state_e state_ff, nxt_state;
    logic [7:0] tmr_ff, nxt_tmr;
    logic [15:0] sh_ff, nxt_sh;
    logic [15:0] src;
    logic [6:0] rx_ff, nxt_rx;
    logic hdr_ff, nxt_hdr;
    logic [3:0] bit_ff, nxt_bit;
    logic [7:0] left_ff, nxt_left;
    logic dir_ff, nxt_dir;
    logic cs_n_ff, nxt_cs_n;
    logic sclk_ff, nxt_sclk;
    logic mosi_ff, nxt_mosi;
    logic busy_ff, nxt_busy;
    logic take_ff, nxt_take;
    logic rdv_ff, nxt_rdv;
    logic [srt_pkg::DATA_W-1:0] rdd_ff, nxt_rdd;
    logic done_ff, nxt_done;
    logic [2:0] msy_ff;
    logic miso_v_ff, nxt_miso_v;
    logic tmr_end;
    logic go_low;
    logic load;

    assign tmr_end = (tmr_ff == 8'(HALF - 1));

    // Clock divider and frame sequencer; idle clock level is high
    always_comb begin
        nxt_state = state_ff;
        nxt_tmr = tmr_end ? 8'h00 : tmr_ff + 8'h01;
        nxt_sh = sh_ff;
        nxt_rx = rx_ff;
        nxt_hdr = hdr_ff;
        nxt_bit = bit_ff;
        nxt_left = left_ff;
        nxt_dir = dir_ff;
        nxt_cs_n = cs_n_ff;
        nxt_sclk = sclk_ff;
        nxt_mosi = mosi_ff;
        nxt_busy = busy_ff;
        nxt_take = 1'b0;
        nxt_rdv = 1'b0;
        nxt_rdd = rdd_ff;
        nxt_done = 1'b0;
        go_low = 1'b0;
        load = 1'b0;
        src = sh_ff;
        unique case (state_ff)
            srt_pkg::HS_IDLE: begin
                nxt_tmr = 8'h00;
                if (cmd_valid) begin
                    nxt_sh = {cmd_write ? srt_pkg::DIR_WRITE : srt_pkg::DIR_READ, cmd_addr};
                    nxt_dir = cmd_write;
                    nxt_left = cmd_extra;
                    nxt_hdr = 1'b1;
                    nxt_bit = 4'h0;
                    nxt_cs_n = 1'b0;
                    nxt_busy = 1'b1;
                    nxt_state = srt_pkg::HS_SEL;
                end
            end
            srt_pkg::HS_SEL: begin
                go_low = tmr_end;
            end
            srt_pkg::HS_LOW: begin
                if (tmr_end) begin
                    nxt_sclk = 1'b1;
                    nxt_state = srt_pkg::HS_HIGH;
                end
            end
            srt_pkg::HS_HIGH: begin
                if (tmr_end) begin
                    // Sample late in the high phase, well after the target's falling-edge change
                    nxt_rx = {rx_ff[5:0], miso_v_ff};
                    nxt_bit = bit_ff + 4'h1;
                    go_low = 1'b1;
                    if (hdr_ff && bit_ff == srt_pkg::HDR_LAST) begin
                        nxt_hdr = 1'b0;
                        nxt_bit = 4'h0;
                        load = dir_ff;
                    end else if (!hdr_ff && bit_ff == srt_pkg::DATA_LAST) begin
                        nxt_bit = 4'h0;
                        nxt_rdv = ~dir_ff;
                        nxt_rdd = {rx_ff, miso_v_ff};
                        if (left_ff == 8'h00) begin
                            go_low = 1'b0;
                            nxt_state = srt_pkg::HS_END;
                        end else begin
                            nxt_left = left_ff - 8'h01;
                            load = dir_ff;
                        end
                    end
                end
            end
            srt_pkg::HS_END: begin
                if (tmr_end) begin
                    nxt_cs_n = 1'b1;
                    nxt_busy = 1'b0;
                    nxt_done = 1'b1;
                    nxt_state = srt_pkg::HS_IDLE;
                end
            end
            default: begin
                nxt_state = srt_pkg::HS_IDLE;
            end
        endcase
        if (go_low) begin
            src = load ? {cmd_wdata, 8'h00} : sh_ff;
            nxt_mosi = src[15];
            nxt_sh = {src[14:0], 1'b0};
            nxt_sclk = 1'b0;
            nxt_take = load;
            nxt_state = srt_pkg::HS_LOW;
        end
    end

    // Target output passes three flops; a change counts once the last two agree
    assign nxt_miso_v = (msy_ff[1] == msy_ff[2]) ? msy_ff[2] : miso_v_ff;

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            state_ff <= srt_pkg::HS_IDLE;
            tmr_ff <= 8'h00;
            sh_ff <= 16'h0000;
            rx_ff <= 7'h00;
            hdr_ff <= 1'b0;
            bit_ff <= 4'h0;
            left_ff <= 8'h00;
            dir_ff <= srt_pkg::DIR_READ;
            cs_n_ff <= 1'b1;
            sclk_ff <= 1'b1;
            mosi_ff <= 1'b0;
            busy_ff <= 1'b0;
            take_ff <= 1'b0;
            rdv_ff <= 1'b0;
            rdd_ff <= srt_pkg::DATA_RST;
            done_ff <= 1'b0;
            msy_ff <= 3'h0;
            miso_v_ff <= 1'b0;
        end else begin
            state_ff <= nxt_state;
            tmr_ff <= nxt_tmr;
            sh_ff <= nxt_sh;
            rx_ff <= nxt_rx;
            hdr_ff <= nxt_hdr;
            bit_ff <= nxt_bit;
            left_ff <= nxt_left;
            dir_ff <= nxt_dir;
            cs_n_ff <= nxt_cs_n;
            sclk_ff <= nxt_sclk;
            mosi_ff <= nxt_mosi;
            busy_ff <= nxt_busy;
            take_ff <= nxt_take;
            rdv_ff <= nxt_rdv;
            rdd_ff <= nxt_rdd;
            done_ff <= nxt_done;
            msy_ff <= {msy_ff[1:0], link.miso};
            miso_v_ff <= nxt_miso_v;
        end
    end

    assign link.cs_n = cs_n_ff;
    assign link.sclk = sclk_ff;
    assign link.mosi = mosi_ff;
    assign busy = busy_ff;
    assign wdata_take = take_ff;
    assign rd_valid = rdv_ff;
    assign rd_data = rdd_ff;
    assign done = done_ff;
endmodule : srt_controller
`default_nettype wire

/* File: testbench/srt_link_chk.sv */
`timescale 1ns/1ps
`default_nettype none
module srt_link_chk (
    input wire logic clock,
    input wire logic nrst,
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic mosi,
    input wire logic miso
);
    logic [7:0] rise_ff;
    logic [7:0] nxt_rise;
    logic bit_ff;
    logic nxt_bit;
    logic sclk_ff;

    // Count serial rising edges within a frame; last sampled host bit kept for the echo check
    always_comb begin
        nxt_rise = rise_ff;
        nxt_bit = bit_ff;
        if (cs_n) begin
            nxt_rise = 8'h00;
        end else if (sclk && !sclk_ff) begin
            nxt_rise = rise_ff + 8'h01;
            nxt_bit = mosi;
        end
    end

    always_ff @(posedge clock or negedge nrst) begin
        if (!nrst) begin
            rise_ff <= 8'h00;
            bit_ff <= 1'b0;
            sclk_ff <= 1'b1;
        end else begin
            rise_ff <= nxt_rise;
            bit_ff <= nxt_bit;
            sclk_ff <= sclk;
        end
    end

    default clocking cb @(posedge clock); endclocking
    default disable iff (!nrst);

    miso_idle_a: assert property (cs_n |-> !miso)
        else $error("target output not low while deselected");
    sclk_idle_a: assert property (cs_n |-> sclk)
        else $error("serial clock not high while deselected");
    sel_setup_a: assert property ($fell(cs_n) |-> sclk [*5])
        else $error("serial clock fell too soon after select");
    low_half_a: assert property ($fell(sclk) |-> !sclk [*8])
        else $error("serial clock low phase too short");
    mosi_hold_a: assert property (sclk && $past(sclk) |-> $stable(mosi))
        else $error("host data moved while clock high");
    miso_edge_a: assert property (!cs_n && $changed(miso) && rise_ff > 8'h02 |-> !sclk)
        else $error("target data moved while clock high");
    echo_bit_a: assert property ($fell(sclk) && rise_ff > 8'h02 && rise_ff < 8'h10 |-> miso == bit_ff)
        else $error("address bit not echoed");
    frame_len_a: assert property ($rose(cs_n) |-> rise_ff >= 8'h18 && rise_ff[2:0] == 3'h0)
        else $error("frame not whole header plus bytes");
endmodule : srt_link_chk
`default_nettype wire

/* File: testbench/spi_register_target_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module spi_register_target_bench;
    localparam logic [7:0] REV = 8'hc3; // Arbitrary value
    logic clock, nrst, cmd_valid, cmd_write, busy, wdata_take, rd_valid, done, wv_a, wv_b;
    logic [14:0] cmd_addr, wa_a, wa_b;
    logic [7:0] cmd_extra, cmd_wdata, rd_data, wd_a, wd_b;
    logic [7:0] mem [16];
    logic [7:0] wb [8];
    logic [22:0] eq[$];
    logic [22:0] wq[$];
    logic [7:0] rq[$];
    logic [31:0] seed, cap;
    int n_fail, n_compared, nb;
    srt_link_if la ();
    srt_link_if lb ();
    srt_controller u_srt_controller (.clock(clock), .nrst(nrst), .link(la), .cmd_valid(cmd_valid),
        .cmd_write(cmd_write), .cmd_addr(cmd_addr), .cmd_extra(cmd_extra), .cmd_wdata(cmd_wdata), .busy(busy),
        .wdata_take(wdata_take), .rd_valid(rd_valid), .rd_data(rd_data), .done(done));
    srt_target #(.NUM_REGS(16), .REVISION(REV)) u_srt_target (.clock(clock), .nrst(nrst), .link(la),
        .wr_valid(wv_a), .wr_addr(wa_a), .wr_data(wd_a));
    // Second target faces the bench, which breaks the host's rules on purpose
    srt_target #(.NUM_REGS(16), .REVISION(REV)) u_srt_target_b (.clock(clock), .nrst(nrst), .link(lb),
        .wr_valid(wv_b), .wr_addr(wa_b), .wr_data(wd_b));
    srt_link_chk u_srt_link_chk (.clock(clock), .nrst(nrst), .cs_n(la.cs_n), .sclk(la.sclk), .mosi(la.mosi),
        .miso(la.miso));

    initial begin
        clock = 1'b0;
        forever #10 clock = ~clock;
    end

    // Pulses are sampled before the edge's own updates land
    always @(posedge clock) begin
        if (rd_valid === 1'b1) rq.push_back(rd_data);
        if (wv_a === 1'b1) wq.push_back({wa_a, wd_a});
        if (wv_b === 1'b1) nb++;
    end

    function automatic logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction : rnd

    function automatic logic [7:0] exp_rd(input int a);
        if (a < 16) return mem[a];
        return a == int'(srt_pkg::REV_ADDR) ? REV : 8'h00;
    endfunction : exp_rd

    task automatic chk(input string what, input logic [22:0] exp, input logic [22:0] got);
        n_compared++;
        if (got !== exp) begin
            n_fail++;
            $display("unexpected %s: expected %h, seen %h", what, exp, got);
        end
    endtask : chk

    task automatic chk_n(input string what, input int exp, input int got);
        n_compared++;
        if (got != exp) begin
            n_fail++;
            $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
        end
    endtask : chk_n

    task automatic final_report();
        $display("compared %0d, mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("TEST PASSED");
        else $display("TEST FAILED");
        $finish;
    endtask : final_report

    // One controller command; next write byte is presented after each take
    task automatic run(input logic w, input logic [14:0] a, input int x);
        int t;
        int k;
        k = 0;
        @(posedge clock);
        cmd_valid <= 1'b1;
        cmd_write <= w;
        cmd_addr <= a;
        cmd_extra <= 8'(x);
        cmd_wdata <= wb[0];
        @(posedge clock);
        cmd_valid <= 1'b0;
        for (t = 0; t < 9000 && done !== 1'b1; t++) begin
            @(posedge clock);
            if (t == 0) chk("busy", 23'h1, 23'(busy));
            if (wdata_take === 1'b1) begin
                k++;
                cmd_wdata <= wb[k % 8];
            end
        end
        if (t == 9000) begin
            chk_n("done", 1, 0);
            final_report();
        end
        chk("busy end", 23'h0, 23'(busy));
    endtask : run

    // Bench-made serial frame at 48 ns; p picks a bit after which the clock pauses
    task automatic sb(input logic [31:0] v, input int n, input int p);
        cap = 32'h0;
        lb.cs_n <= 1'b0;
        #30;
        for (int i = n - 1; i >= 0; i--) begin
            lb.sclk <= 1'b0;
            lb.mosi <= v[i];
            #24;
            cap = {cap[30:0], lb.miso};
            lb.sclk <= 1'b1;
            #24;
            if (i == p) #1000;
        end
        #30;
        lb.cs_n <= 1'b1;
        #100;
    endtask : sb

    initial begin
        int i, k, x, a;
        seed = 32'h00005c23;
        n_fail = 0;
        n_compared = 0;
        nb = 0;
        nrst = 1'b0;
        {cmd_valid, cmd_write, cmd_addr, cmd_extra, cmd_wdata} = '0;
        lb.cs_n = 1'b1;
        lb.sclk = 1'b1;
        lb.mosi = 1'b0;
        foreach (mem[j]) mem[j] = 8'h00;
        repeat (20) @(posedge clock);
        nrst <= 1'b1;
        for (i = 0; i < 14; i++) begin
            a = int'(rnd() % 32'h10);
            x = int'(rnd() % 32'h4);
            if (i == 0) {a, x} = {32'hf, 32'h2};
            if (i == 1) {a, x} = {32'h7fff, 32'h0};
            for (k = 0; k <= x; k++) begin
                wb[k] = 8'(rnd());
                if (a + k < 16) begin
                    mem[a + k] = wb[k];
                    eq.push_back({15'(a + k), wb[k]});
                end
            end
            run(1'b1, 15'(a), x);
            repeat (8) @(posedge clock);
            chk_n("write count", eq.size(), wq.size());
            while (eq.size() > 0 && wq.size() > 0) chk("write", eq.pop_front(), wq.pop_front());
            eq.delete();
            wq.delete();
        end
        $display("write test done");
        for (i = 0; i < 14; i++) begin
            a = int'(rnd() % 32'h14);
            x = int'(rnd() % 32'h4);
            if (i == 0) {a, x} = {32'he, 32'h3};
            if (i == 1) {a, x} = {32'h7ffe, 32'h1};
            run(1'b0, 15'(a), x);
            chk_n("read count", x + 1, rq.size());
            for (k = 0; k <= x && rq.size() > 0; k++) chk("read", exp_rd(a + k), rq.pop_front());
            rq.delete();
        end
        $display("read test done");
        // Clock and data wiggle while deselected must leave no trace
        repeat (24) begin
            lb.sclk <= ~lb.sclk;
            lb.mosi <= ~lb.mosi;
            #24;
        end
        sb({8'h00, 1'b1, 15'h0003, 8'ha5}, 24, 20);
        #200;
        chk_n("notice b", 1, nb);
        chk("write b", {15'h0003, 8'ha5}, {wa_b, wd_b});
        sb({12'h000, 1'b1, 15'h0003, 4'h3}, 20, -1);
        #200;
        chk_n("abort b", 1, nb);
        sb({1'b0, 15'h0003, 16'h0000}, 32, -1);
        chk("read b", {7'h00, 8'ha5, 8'h00}, 23'(cap[15:0]));
        sb({8'h00, 1'b0, 15'h2aab, 8'h00}, 24, -1);
        chk("echo b", 23'(15'h1555), 23'(cap[21:8]));
        chk("unused b", 23'h0, 23'(cap[7:0]));
        $display("link b test done");
        final_report();
    end
endmodule : spi_register_target_bench
`default_nettype wire
